// file: include/manual_sel_pkg.sv
/*
  shared constants for the manual axis select and feed control block.
  assumes a four-axis machine driven by a ladder program through plain ports.
*/
package manual_sel_pkg;
  localparam int AXES      = 4;                 // configured axis count
  localparam int AXNUM_W   = 5;                 // axis-number field width
  localparam int FEED_W    = 32;                // feedrate word width
  localparam int MOVE_W    = 32;                // one movement-data word
  localparam int SLOTS     = 3;                 // point-to-point slots
  localparam int SCAN_W    = 16;                // scan counter width
  localparam logic [SCAN_W-1:0] SCAN_CYCLES = 16'h0FA0; // cycles per scan
  localparam logic [AXES-1:0]   AXES_NONE   = 4'h0;
  localparam logic [FEED_W-1:0] FEED_ZERO   = 32'h0;
  localparam logic [1:0]        WHEELS_THREE = 2'h3; // three-handwheel setup
  typedef enum logic [1:0] {
    FB_IDLE,
    FB_RUN,
    FB_STOP_WAIT
  } fb_state_type;
endpackage : manual_sel_pkg

// file: src/manual_axis_select_feed_ctrl.sv
/*
  manual axis selection, alternate jog feedrate and point-to-point axis slots.
  assumes selection inputs come from the ladder on this clock; a scan tick
  is derived internally and handwheel and jog selections are sampled on it; slot numbers latch at start.
*/
`timescale 1ns/1ps
// Contract
// [RQ1] program selects handle mode, loads third axis number, asserts valid before turning
// [RQ2] third axis number decoded binary, 1..4 pick axes, gated by valid
// [RQ3] third valid acts like first valid, only with three wheels configured
// [RQ4] enabled axis in jog moves at alternate feedrate, enable per axis
// [RQ5] per-axis switch off uses common rate, on uses each axis rate
// [RQ6] alternate feedrate only in jog, enables ignored in other modes
// [RQ7] alternate-feed axis ignores rapid traverse and manual override
// [RQ8] reset stops alternate-feed axis; restart needs reset release, direction toggle
// [RQ9] direction raised with zero alternate rate flags error, axis stays
// [RQ10] program holds simultaneous bit to use alternate feed in auto
// [RQ11] program asserts jog with other manual mode to use alternate feed
// [RQ12] sync follower ignores own enable, follows master enable
// [RQ13] axis numbers loaded before start; changes during motion rejected
// [RQ14] three slots move together, axes in any order
// [RQ15] each slot axis number valid only with its valid bit
// [RQ16] slot axis number five bits, 1..4 select axes
// [RQ17] each slot takes movement from its own two-word pair
// [RQ18] handwheel selection changes apply only after axis motion stops
// [RQ19] zero or unconfigured axis number selects nothing
// [RQ20] selections sampled once per scan, used consistently
module manual_axis_select_feed_ctrl (
  // clock, reset, enable
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_srst,
  input  wire logic                                i_ce,
  // mode and configuration
  input  wire logic                                i_handle_mode,
  input  wire logic                                i_jog_mode,
  input  wire logic                                i_auto_run,
  input  wire logic                                i_man_auto_sim,
  input  wire logic                                i_point_to_point_feed_mode,
  input  wire logic [1:0]                          i_wheel_count,
  input  wire logic                                i_nc_reset,
  input  wire logic                                i_rapid_sel,
  input  wire logic [manual_sel_pkg::FEED_W-1:0]   i_manual_feed,
  input  wire logic [manual_sel_pkg::FEED_W-1:0]   i_rapid_feed,
  input  wire logic [7:0]                          i_override_pct,
  // handwheel selections
  input  wire logic [manual_sel_pkg::AXNUM_W-1:0]  i_first_wheel_axis_num,
  input  wire logic                                i_first_wheel_valid,
  input  wire logic [manual_sel_pkg::AXNUM_W-1:0]  i_third_wheel_axis_num,
  input  wire logic                                i_third_wheel_valid,
  input  wire logic [manual_sel_pkg::AXES-1:0]     i_axis_moving,
  // alternate jog feedrate
  input  wire logic [manual_sel_pkg::AXES-1:0]     i_altfeed_en,
  input  wire logic                                i_altfeed_each,
  input  wire logic [manual_sel_pkg::FEED_W-1:0]   i_altfeed_common,
  input  wire logic [manual_sel_pkg::AXES*manual_sel_pkg::FEED_W-1:0] i_altfeed_each_rate,
  input  wire logic [manual_sel_pkg::AXES-1:0]     i_dir_sel,
  input  wire logic [manual_sel_pkg::AXES-1:0]     i_sync_follower,
  input  wire logic [manual_sel_pkg::AXES*2-1:0]   i_sync_master,
  // point-to-point slots
  input  wire logic [manual_sel_pkg::AXNUM_W-1:0]  i_ptp_slot1_axis_num,
  input  wire logic [manual_sel_pkg::AXNUM_W-1:0]  i_ptp_slot2_axis_num,
  input  wire logic [manual_sel_pkg::AXNUM_W-1:0]  i_ptp_slot3_axis_num,
  input  wire logic                                i_ptp_slot1_valid,
  input  wire logic                                i_ptp_slot2_valid,
  input  wire logic                                i_ptp_slot3_valid,
  input  wire logic                                i_ptp_start_strobe,
  input  wire logic [manual_sel_pkg::SLOTS*2*manual_sel_pkg::MOVE_W-1:0] i_ptp_move_data,
  // outputs
  output logic [manual_sel_pkg::AXES-1:0]          o_first_wheel_axes,
  output logic [manual_sel_pkg::AXES-1:0]          o_third_wheel_axes,
  output logic [manual_sel_pkg::AXES-1:0]          o_altfeed_active,
  output logic [manual_sel_pkg::AXES*manual_sel_pkg::FEED_W-1:0] o_axis_feed,
  output logic [manual_sel_pkg::AXES-1:0]          o_altfeed_error,
  output logic [manual_sel_pkg::AXES-1:0]          o_ptp_axes,
  output logic [manual_sel_pkg::AXES*2*manual_sel_pkg::MOVE_W-1:0] o_ptp_axis_move,
  output logic                                     o_ptp_busy,
  output logic                                     o_ptp_reject,
  output logic                                     o_scan_tick
);
  import manual_sel_pkg::*;

  // axis-number decode to one-hot, zero or out-of-range gives none
  function automatic logic [AXES-1:0] axis_decode(input logic [AXNUM_W-1:0] num,
                                                  input logic vld);
    logic [AXES-1:0] oh;
    oh = AXES_NONE;
    for (int a = 0; a < AXES; a++) begin
      if (vld && num == AXNUM_W'(a + 1)) begin
        oh[a] = 1'b1;
      end
    end
    return oh;
  endfunction : axis_decode

  // scan timer
  logic [SCAN_W-1:0] scan_cnt_r;
  logic [SCAN_W-1:0] scan_cnt_nxt;
  wire               scan_tick = (scan_cnt_r == SCAN_CYCLES - 16'h1);
  assign scan_cnt_nxt = scan_tick ? '0 : scan_cnt_r + 16'h1;
  assign o_scan_tick  = scan_tick;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) scan_cnt_r <= '0;
    else if (i_ce) scan_cnt_r <= scan_cnt_nxt;
  end

  // [RQ20] scan sampling of selections
  logic [AXES-1:0] en_s_r, dir_s_r, dir_prev_r;
  logic            jog_s_r, each_s_r, auto_s_r, sim_s_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      en_s_r     <= AXES_NONE;
      dir_s_r    <= AXES_NONE;
      dir_prev_r <= AXES_NONE;
      jog_s_r    <= 1'b0;
      each_s_r   <= 1'b0;
      auto_s_r   <= 1'b0;
      sim_s_r    <= 1'b0;
    end else if (i_ce && scan_tick) begin
      en_s_r     <= i_altfeed_en;
      dir_prev_r <= dir_s_r;
      dir_s_r    <= i_dir_sel;
      jog_s_r    <= i_jog_mode;
      each_s_r   <= i_altfeed_each;
      auto_s_r   <= i_auto_run;
      sim_s_r    <= i_man_auto_sim;
    end
  end

  // [RQ2] handwheel decode; [RQ3] third wheel only with three wheels
  wire             three_wheels = (i_wheel_count == WHEELS_THREE);
  wire [AXES-1:0]  first_dec = axis_decode(i_first_wheel_axis_num,
                                           i_handle_mode && i_first_wheel_valid);
  wire [AXES-1:0]  third_dec = axis_decode(i_third_wheel_axis_num,
                                           i_handle_mode && i_third_wheel_valid && three_wheels);

  // [RQ18] each selection updates only once its own selected axis is stopped
  wire first_hold = |(o_first_wheel_axes & i_axis_moving);
  wire third_hold = |(o_third_wheel_axes & i_axis_moving);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_first_wheel_axes <= AXES_NONE;
      o_third_wheel_axes <= AXES_NONE;
    end else if (i_ce && scan_tick) begin
      if (!first_hold) o_first_wheel_axes <= first_dec;
      if (!third_hold) o_third_wheel_axes <= third_dec;
    end
  end

  // [RQ12] follower takes master enable; [RQ6] jog only, auto needs sim bit
  logic [AXES-1:0] eff_en;
  wire  jog_ok = jog_s_r && (!auto_s_r || sim_s_r);
  logic [AXES-1:0] armed_r;
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      wire [1:0]        mst     = i_sync_master[g*2 +: 2];
      wire [FEED_W-1:0] each_rt = i_altfeed_each_rate[g*FEED_W +: FEED_W];
      wire              rising  = dir_s_r[g] && !dir_prev_r[g];
      // [RQ5] common or per-axis rate
      wire [FEED_W-1:0] alt_rt  = each_s_r ? each_rt : i_altfeed_common;
      wire [FEED_W-1:0] ovr_rt  = FEED_W'((64'(i_manual_feed) * 64'(i_override_pct)) >> 7);
      assign eff_en[g] = jog_ok && (i_sync_follower[g] ? en_s_r[mst] : en_s_r[g]);
      // [RQ8] reset stops; rearm on fresh direction rising edge
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          armed_r[g]         <= 1'b0;
          o_altfeed_error[g] <= 1'b0;
        end else if (i_ce) begin
          if (i_nc_reset) begin
            armed_r[g] <= 1'b0;
          end else if (scan_tick) begin
            // [RQ9] zero rate gives error and no motion
            if (rising && eff_en[g] && alt_rt == FEED_ZERO) begin
              o_altfeed_error[g] <= 1'b1;
              armed_r[g]         <= 1'b0;
            end else if (rising) begin
              o_altfeed_error[g] <= 1'b0;
              armed_r[g]         <= 1'b1;
            end else if (!dir_s_r[g]) begin
              armed_r[g] <= 1'b0;
            end
          end
        end
      end
      // [RQ4] alternate rate replaces manual; [RQ7] no rapid, no override
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          o_axis_feed[g*FEED_W +: FEED_W] <= FEED_ZERO;
          o_altfeed_active[g]             <= 1'b0;
        end else if (i_ce) begin
          o_altfeed_active[g] <= eff_en[g] && armed_r[g] && !i_nc_reset;
          if (eff_en[g])
            o_axis_feed[g*FEED_W +: FEED_W] <= (armed_r[g] && !i_nc_reset) ? alt_rt : FEED_ZERO;
          else
            o_axis_feed[g*FEED_W +: FEED_W] <= i_rapid_sel ? i_rapid_feed : ovr_rt;
        end
      end
    end
  endgenerate

  // [RQ15] [RQ16] [RQ19] slot decode, zero or unconfigured selects none
  wire [AXES-1:0] s1 = axis_decode(i_ptp_slot1_axis_num, i_ptp_slot1_valid);
  wire [AXES-1:0] s2 = axis_decode(i_ptp_slot2_axis_num, i_ptp_slot2_valid);
  wire [AXES-1:0] s3 = axis_decode(i_ptp_slot3_axis_num, i_ptp_slot3_valid);
  logic [SLOTS*AXNUM_W-1:0] ptp_num_r;
  wire  [SLOTS*AXNUM_W-1:0] ptp_num_in = {i_ptp_slot3_axis_num, i_ptp_slot2_axis_num,
                                          i_ptp_slot1_axis_num};
  logic strobe_prev_r;
  wire  ptp_start = i_point_to_point_feed_mode && i_ptp_start_strobe && !strobe_prev_r;
  wire  ptp_done  = o_ptp_busy && !(|(o_ptp_axes & i_axis_moving)) && !ptp_start;

  // [RQ13] latch on start, reject changes while busy
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_ptp_axes    <= AXES_NONE;
      o_ptp_busy    <= 1'b0;
      o_ptp_reject  <= 1'b0;
      strobe_prev_r <= 1'b0;
      ptp_num_r     <= '0;
    end else if (i_ce) begin
      strobe_prev_r <= i_ptp_start_strobe;
      o_ptp_reject  <= o_ptp_busy && (ptp_num_in != ptp_num_r);
      if (ptp_start && !o_ptp_busy) begin
        // [RQ14] three slots merged, any order
        o_ptp_axes <= s1 | s2 | s3;
        o_ptp_busy <= 1'b1;
        ptp_num_r  <= ptp_num_in;
      end else if (ptp_done || i_nc_reset) begin
        o_ptp_busy <= 1'b0;
        o_ptp_axes <= AXES_NONE;
      end
    end
  end

  // [RQ17] movement pair of each slot routed to its axis
  generate
    for (g = 0; g < AXES; g++) begin : g_move
      wire [2*MOVE_W-1:0] pick = s1[g] ? i_ptp_move_data[0 +: 2*MOVE_W] :
                                 s2[g] ? i_ptp_move_data[2*MOVE_W +: 2*MOVE_W] :
                                 s3[g] ? i_ptp_move_data[4*MOVE_W +: 2*MOVE_W] : '0;
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) o_ptp_axis_move[g*2*MOVE_W +: 2*MOVE_W] <= '0;
        else if (i_ce && ptp_start && !o_ptp_busy)
          o_ptp_axis_move[g*2*MOVE_W +: 2*MOVE_W] <= pick;
      end
    end
  endgenerate

  // checks
  a_ptp_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ13]
    (o_ptp_busy && i_ce && !ptp_done && !i_nc_reset) |=> $stable(o_ptp_axes))
    else $error("slot axes changed during motion");
  a_third_gate: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ3]
    (i_ce && scan_tick && !three_wheels && !third_hold) |=> o_third_wheel_axes == AXES_NONE)
    else $error("third wheel active without three wheels");
  a_reset_stop: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ8]
    (i_ce && i_nc_reset) |=> o_altfeed_active == AXES_NONE)
    else $error("alternate feed kept running on reset");
  a_zero_err: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ9]
    (|(o_altfeed_error & o_altfeed_active)) == 1'b0)
    else $error("axis moving while flagged");
  a_jog_only: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ6]
    (i_ce && !jog_s_r) |=> o_altfeed_active == AXES_NONE)
    else $error("alternate feed outside jog");
  a_ptp_decode: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ19]
    (i_ce && ptp_start && !o_ptp_busy) |=> o_ptp_axes == $past(s1 | s2 | s3))
    else $error("slot decode mismatch");

  // [RQ2] first wheel decode lands at the scan tick
  a_wheel_decode: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ2]
    (i_ce && scan_tick && !first_hold) |=> o_first_wheel_axes == $past(first_dec))
    else $error("first wheel decode mismatch");

  // [RQ18] selection held while a selected axis moves
  a_wheel_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ18]
    (i_ce && scan_tick && first_hold) |=> $stable(o_first_wheel_axes))
    else $error("first wheel selection changed during motion");

  // [RQ4] armed and enabled axis runs at alternate feed
  a_alt_active: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ4]
    (i_ce && eff_en[0] && armed_r[0] && !i_nc_reset) |=> o_altfeed_active[0])
    else $error("alternate feed not active");

  // [RQ7] alternate axis takes its alternate rate only
  a_alt_rate: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ7]
    (i_ce && eff_en[0] && armed_r[0] && !i_nc_reset)
      |=> o_axis_feed[FEED_W-1:0] == $past(g_axis[0].alt_rt))
    else $error("alternate axis feed not alternate rate");

  // [RQ8] controller reset disarms every axis
  a_reset_disarm: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ8]
    (i_ce && i_nc_reset) |=> armed_r == AXES_NONE)
    else $error("axis still armed after reset");

  // [RQ13] changed slot number while busy is flagged
  a_reject_flag: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ13]
    (i_ce && o_ptp_busy && ptp_num_in != ptp_num_r) |=> o_ptp_reject)
    else $error("slot change during motion not flagged");

  // [RQ20] scan tick is a single-cycle pulse
  a_scan_pulse: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ20]
    (i_ce && scan_tick) |=> !scan_tick)
    else $error("scan tick longer than one cycle");

  c_ptp_run:  cover property (@(posedge i_clk_sys) o_ptp_busy ##1 !o_ptp_busy);
  c_alt_run:  cover property (@(posedge i_clk_sys) |o_altfeed_active);
  c_alt_err:  cover property (@(posedge i_clk_sys) |o_altfeed_error);
  c_third_on: cover property (@(posedge i_clk_sys) |o_third_wheel_axes);
  c_ptp_rej:  cover property (@(posedge i_clk_sys) o_ptp_reject);
endmodule : manual_axis_select_feed_ctrl

// file: sim/ladder_model.sv
/*
  ladder program model that drives the direction-select and simultaneous bits.
  assumes it sees the block's scan tick and updates on the falling clock edge.
*/
`timescale 1ns/1ps
module ladder_model (
  // clock and scan
  input  wire logic       i_clk_sys,
  input  wire logic       i_scan_tick,
  // requests from the bench
  input  wire logic       i_nc_reset,
  input  wire logic       i_auto_run,
  input  wire logic [3:0] i_want_move,
  // selection bits toward the block
  output logic      [3:0] o_dir_sel,
  output logic            o_man_auto_sim
);
  initial o_dir_sel = 4'h0;
  // drop direction when reset is seen at a scan tick
  // direction follows the request once per scan, so a release re-arms by toggling
  always @(negedge i_clk_sys) begin
    if (i_scan_tick) begin
      o_dir_sel <= i_nc_reset ? 4'h0 : i_want_move;
    end
  end
  assign o_man_auto_sim = i_auto_run; // follows automatic run
endmodule : ladder_model

// file: sim/tb_top.sv
/*
  self-checking bench for the manual axis select and feed control block.
  assumes the package constants and a ladder model driving direction bits.
*/
`timescale 1ns/1ps
module tb_top;
  import manual_sel_pkg::*;
  logic i_clk_sys = 0, i_srst = 1, i_ce = 1, i_handle_mode = 1, i_jog_mode = 1;
  logic i_auto_run = 0, i_point_to_point_feed_mode = 0, i_nc_reset = 0, i_rapid_sel = 1;
  logic i_altfeed_each = 1, i_first_wheel_valid = 0, i_third_wheel_valid = 0;
  logic i_ptp_slot1_valid = 0, i_ptp_slot2_valid = 0, i_ptp_slot3_valid = 0;
  logic i_ptp_start_strobe = 0, i_man_auto_sim, o_ptp_busy, o_ptp_reject, o_scan_tick;
  logic [1:0]   i_wheel_count = 2'h3;
  logic [7:0]   i_override_pct = 8'h80, i_sync_master = 8'h00;
  logic [4:0]   i_first_wheel_axis_num = 0, i_third_wheel_axis_num = 0;
  logic [4:0]   i_ptp_slot1_axis_num = 0, i_ptp_slot2_axis_num = 0, i_ptp_slot3_axis_num = 0;
  logic [3:0]   i_axis_moving = 0, i_altfeed_en = 0, i_dir_sel, i_sync_follower = 0;
  logic [3:0]   want = 0, pf, pt, o_first_wheel_axes, o_third_wheel_axes;
  logic [3:0]   o_altfeed_active, o_altfeed_error, o_ptp_axes;
  logic [31:0]  i_manual_feed = 0, i_rapid_feed = 0, i_altfeed_common = 0;
  logic [127:0] i_altfeed_each_rate = 0, o_axis_feed;
  logic [191:0] i_ptp_move_data = 0;
  logic [255:0] o_ptp_axis_move;
  int           seed = 32'h8a0119bf, failures = 0, checks = 0, s;

  ladder_model u_ladder (.i_clk_sys(i_clk_sys), .i_scan_tick(o_scan_tick),
    .i_nc_reset(i_nc_reset), .i_auto_run(i_auto_run), .i_want_move(want),
    .o_dir_sel(i_dir_sel), .o_man_auto_sim(i_man_auto_sim));
  manual_axis_select_feed_ctrl u_dut (.*);

  // clock and watchdog
  always #2 i_clk_sys = ~i_clk_sys;
  initial begin
    #240000;
    failures++;
    close_out();
  end

  // one-hot axis expected from a five-bit number and its valid bit
  function automatic logic [3:0] dec(input logic [4:0] n, input logic v);
    return (v && n >= 5'h1 && n <= 5'h4) ? 4'h1 << (n - 5'h1) : AXES_NONE;
  endfunction : dec

  task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // wait for a scan tick, then let the sampled outputs settle
  task automatic tick();
    int n;
    for (n = 0; n < 4100; n++) begin
      @(negedge i_clk_sys);
      if (o_scan_tick === 1'b1) break;
    end
    if (n == 4100) failures++;
    @(posedge i_clk_sys);
    repeat (3) @(negedge i_clk_sys);
  endtask : tick

  // main sequence
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_srst = 0;
    for (s = 0; s < 6; s++) i_ptp_move_data[s*32+:32] = $random(seed);
    i_point_to_point_feed_mode = 1;
    i_ptp_slot1_axis_num = 5'h4; // descending order on purpose
    i_ptp_slot2_axis_num = 5'h2;
    i_ptp_slot3_axis_num = 5'h1;
    {i_ptp_slot1_valid, i_ptp_slot2_valid} = 2'h3;
    @(negedge i_clk_sys);
    i_ptp_start_strobe = 1;
    i_axis_moving = 4'hA;
    repeat (3) @(negedge i_clk_sys);
    chk("ptp_busy", o_ptp_busy, 1'b1);
    chk("ptp_axes", o_ptp_axes, dec(5'h4, 1) | dec(5'h2, 1) | dec(5'h1, 0));
    chk("ptp_move4", o_ptp_axis_move[192+:64], i_ptp_move_data[0+:64]);
    chk("ptp_move2", o_ptp_axis_move[64+:64], i_ptp_move_data[64+:64]);
    i_ptp_slot1_axis_num = 5'h1;
    repeat (2) @(negedge i_clk_sys);
    chk("ptp_reject", o_ptp_reject, 1'b1);
    chk("ptp_keep", o_ptp_axes, 4'hA);
    {i_ptp_slot1_axis_num, i_axis_moving, i_ptp_start_strobe} = {5'h4, 4'h0, 1'b0};
    repeat (3) @(negedge i_clk_sys);
    chk("ptp_done", o_ptp_busy, 1'b0);
    i_rapid_feed = $random(seed);
    i_altfeed_en = 4'h5;
    i_altfeed_each_rate[31:0] = $random(seed) | 32'h1; // axis three rate stays zero
    want = 4'h5;
    for (s = 0; s < 10; s++) begin
      // number and valid loaded before use
      i_third_wheel_axis_num = s < 6 ? 5'((s + 1) % 6) : 5'($random(seed));
      i_first_wheel_axis_num = 5'({$random(seed)} % 32'h6);
      {i_first_wheel_valid, i_third_wheel_valid} = s < 6 ? 2'h3 : 2'($random(seed));
      i_wheel_count = s < 6 ? WHEELS_THREE : 2'($random(seed));
      i_override_pct = 8'($random(seed));
      i_manual_feed = $random(seed);
      if (s == 9) i_axis_moving = 4'hF;
      if (s == 3) i_jog_mode = 0;
      if (s == 4) i_jog_mode = 1;
      if (s == 6) want = 4'h0;
      if (s == 7) want = 4'h5;
      if (s == 2) begin
        i_altfeed_each = 0;
        i_altfeed_common = $random(seed) | 32'h1;
      end
      if (s == 5) begin
        i_nc_reset = 1;
        repeat (3) @(negedge i_clk_sys);
        chk("alt_nc_stop", o_altfeed_active[0], 1'b0);
        i_nc_reset = 0;
      end
      tick();
      i_nc_reset = 0;
      if (s != 9 || pf == AXES_NONE) pf = dec(i_first_wheel_axis_num, i_first_wheel_valid);
      if (s != 9 || pt == AXES_NONE)
        pt = dec(i_third_wheel_axis_num, i_third_wheel_valid && i_wheel_count == WHEELS_THREE);
      chk("first_axes", o_first_wheel_axes, pf);
      chk("third_axes", o_third_wheel_axes, pt);
      if (s == 1) begin
        chk("alt_on", o_altfeed_active[0], 1'b1);
        chk("alt_each", o_axis_feed[31:0], i_altfeed_each_rate[31:0]);
        chk("alt_zero", o_altfeed_error[2], 1'b1);
        chk("rapid_feed", o_axis_feed[63:32], i_rapid_feed);
      end
      if (s == 2) chk("alt_common", o_axis_feed[31:0], i_altfeed_common);
      if (s == 3) chk("alt_no_jog", o_altfeed_active, AXES_NONE);
      if (s == 4) chk("alt_jog_back", o_altfeed_active[0], 1'b1);
      if (s == 5) chk("alt_no_rearm", o_altfeed_active[0], 1'b0);
      if (s == 8) chk("alt_rearm", o_altfeed_active[0], 1'b1);
    end
    close_out();
  end
endmodule : tb_top
